// ===== verilog/fsfb_pkg.sv
package fsfb_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FSFB_STATUS_ONE_OFFSET = 8'h01; // Fault status one
  localparam logic [15:0] FSFB_STATUS_RESET = 16'h0000; // All flags clear
  // ----------------------------------------------------------------
  // Field positions in the status word
  // ----------------------------------------------------------------
  localparam int FSFB_BIT_SUPPLY_OV = 12; // Logic supply overvoltage
  localparam int FSFB_BIT_THERM_WARN = 11; // Thermal warning
  localparam int FSFB_BIT_THERM_SD = 10; // Thermal shutdown
  localparam int FSFB_BIT_FAILSAFE = 9; // Fail-safe summary
  localparam int FSFB_BIT_PUMP_PUMP_NOT_READY_BIT = 8; // Charge pump not ready
  localparam int FSFB_BIT_PUMP_LOW = 7; // Charge pump low
  localparam int FSFB_BIT_WATCHDOG = 6; // Watchdog fault
  localparam int FSFB_BIT_IO_OV = 5; // Digital io overvoltage
  localparam int FSFB_BIT_DS_LO = 1; // Lowest drain-source monitor flag
  localparam int FSFB_BIT_DS_HI = 4; // Highest drain-source monitor flag
  // Plain read-and-clear flags handled by one generic latch each
  localparam logic [15:0] FSFB_RC_MASK = 16'h1C7E;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int FSFB_CLK_PERIOD_NS = 10; // 100 MHz logic clock
  localparam int FSFB_PUMP_FILTER_TIME_NS = 10000; // Pump filter time, plain default
  // Least time, so round up
  localparam int FSFB_PUMP_FILTER_CYCLES =
    (FSFB_PUMP_FILTER_TIME_NS + FSFB_CLK_PERIOD_NS - 1) / FSFB_CLK_PERIOD_NS;
endpackage

// ===== verilog/fsfb_level_filter.sv
`timescale 1ns/1ps
// Changes its output only after the input has differed from it for
// CYCLES consecutive clocks; restart forces the low-pump state.
module fsfb_level_filter #(
  parameter int CYCLES = fsfb_pkg::FSFB_PUMP_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic restart,
  // Level
  input wire logic level_in,
  output logic level_out
);
  import fsfb_pkg::*;

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q, cnt_d; // Cycles of disagreement so far
  logic out_q, out_d; // Filtered level

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = '0;
    out_d = out_q;
    if (restart) begin
      // A fresh pump start always begins from the low state
      out_d = 1'b1;
    end else if (level_in != out_q) begin
      if (cnt_q == CNT_LAST) begin
        out_d = level_in;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign level_out = out_q;
endmodule // fsfb_level_filter

// ===== verilog/fsfb_status_bank.sv
`timescale 1ns/1ps
module fsfb_status_bank #(
  parameter int PUMP_FILTER_CYCLES = fsfb_pkg::FSFB_PUMP_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access from the serial interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_rd_clr,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  // Asynchronous fault detector levels
  input wire logic supply_ov_det,
  input wire logic therm_warn_det,
  input wire logic therm_sd_det,
  input wire logic watchdog_det,
  input wire logic io_ov_det,
  input wire logic [3:0] ds_monitor_det,
  input wire logic failsafe_input_pin,
  input wire logic pump_below_det,
  // Same-clock control and neighbour state
  input wire logic pump_enable,
  input wire logic pump_low_live_select,
  input wire logic [3:0] failsafe_fet_flags,
  input wire logic failsafe_pin_flag,
  // Live status word
  output logic [15:0] device_fault_status_one
);
  import fsfb_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [15:0] det_raw; // Detector levels at their bit positions
  logic [15:0] det_meta_q; // First stage, read only by second stage
  logic [15:0] det_q; // Synchronised detector levels
  logic [1:0] pin_meta_q; // Fail-safe pin and pump comparator, stage one
  logic [1:0] pin_q; // Same, stage two

  always_comb begin
    det_raw = '0;
    det_raw[FSFB_BIT_SUPPLY_OV] = supply_ov_det;
    det_raw[FSFB_BIT_THERM_WARN] = therm_warn_det;
    det_raw[FSFB_BIT_THERM_SD] = therm_sd_det;
    det_raw[FSFB_BIT_WATCHDOG] = watchdog_det;
    det_raw[FSFB_BIT_IO_OV] = io_ov_det;
    det_raw[FSFB_BIT_DS_HI:FSFB_BIT_DS_LO] = ds_monitor_det;
  end

  // Two flops on every pin-borne level before any logic sees it
  always_ff @(posedge clk) begin
    if (rst) begin
      det_meta_q <= '0;
      det_q <= '0;
      // Fail-safe stage resets to the pin's released (high) level; a zero here
      // would flash the summary bit for two cycles after every reset
      pin_meta_q <= 2'b10;
      pin_q <= 2'b10;
    end else begin
      det_meta_q <= det_raw;
      det_q <= det_meta_q;
      pin_meta_q <= {failsafe_input_pin, pump_below_det};
      pin_q <= pin_meta_q;
    end
  end

  logic failsafe_pin_low; // Synchronised fail-safe pin held low
  logic pump_below; // Synchronised pump comparator
  assign failsafe_pin_low = ~pin_q[1];
  assign pump_below = pin_q[0];

  // ----------------------------------------------------------------
  // Charge pump filter
  // ----------------------------------------------------------------
  logic pump_en_q; // Enable delayed for edge detection
  logic pump_start; // Enable rising edge
  logic pump_low_filt; // Pump below threshold, filtered
  assign pump_start = pump_enable & ~pump_en_q;

  // One filter serves both pump bits; it restarts at every enable so
  // the not-ready time is measured from the pump start, not earlier.
  fsfb_level_filter #(
    .CYCLES(PUMP_FILTER_CYCLES)
  ) u_pump_filter (
    .clk(clk),
    .rst(rst),
    .restart(pump_start),
    .level_in(pump_below),
    .level_out(pump_low_filt)
  );

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic [15:0] status_q, status_d; // Status word
  logic [15:0] rdata_q, rdata_d; // Read data register
  logic clr_hit; // Read-and-clear aimed at this register
  logic rd_hit; // Any read aimed at this register
  assign rd_hit = (reg_rd | reg_rd_clr) && (reg_addr == FSFB_STATUS_ONE_OFFSET);
  assign clr_hit = reg_rd_clr && (reg_addr == FSFB_STATUS_ONE_OFFSET);

  // Generic latched flags: an active source always wins over the clear,
  // so a clear during a live fault leaves the flag standing
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (FSFB_RC_MASK[gi]) begin : g_rc
        always_comb begin
          status_d[gi] = det_q[gi] | (status_q[gi] & ~clr_hit);
        end
      end else if (gi == FSFB_BIT_FAILSAFE) begin : g_fs
        // Pulled-down floating pin reads low, hence sets the summary
        always_comb begin
          status_d[gi] = failsafe_pin_low | failsafe_pin_flag | (|failsafe_fet_flags);
        end
      end else if (gi == FSFB_BIT_PUMP_PUMP_NOT_READY_BIT) begin : g_pump_not_ready_bit
        // Read only; host clear is not looked at
        always_comb begin
          if (pump_start) begin
            status_d[gi] = 1'b1;
          end else if (pump_enable && !pump_low_filt) begin
            status_d[gi] = 1'b0;
          end else begin
            status_d[gi] = status_q[gi];
          end
        end
      end else if (gi == FSFB_BIT_PUMP_LOW) begin : g_plow
        always_comb begin
          if (pump_low_live_select) begin
            status_d[gi] = pump_low_filt;
          end else begin
            status_d[gi] = pump_low_filt | (status_q[gi] & ~clr_hit);
          end
        end
      end else begin : g_zero
        // Bits owned elsewhere and the parity slot read zero here
        always_comb begin
          status_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // Read data captures the word before any clear of the same access
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd | reg_rd_clr) begin
      rdata_d = rd_hit ? status_q : 16'h0000;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= FSFB_STATUS_RESET;
      rdata_q <= 16'h0000;
      pump_en_q <= 1'b0;
    end else begin
      status_q <= status_d;
      rdata_q <= rdata_d;
      pump_en_q <= pump_enable;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = rd_hit;
  assign device_fault_status_one = status_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_supply_ov_set;
    det_q[FSFB_BIT_SUPPLY_OV] |=> status_q[FSFB_BIT_SUPPLY_OV];
  endproperty
  a_supply_ov_set: assert property (p_supply_ov_set) else $error("supply ov flag not set");

  property p_warn_hold;
    status_q[FSFB_BIT_THERM_WARN] && !clr_hit |=> status_q[FSFB_BIT_THERM_WARN];
  endproperty
  a_warn_hold: assert property (p_warn_hold) else $error("thermal warning lost without clear");

  property p_sd_clear;
    clr_hit && !det_q[FSFB_BIT_THERM_SD] |=> !status_q[FSFB_BIT_THERM_SD];
  endproperty
  a_sd_clear: assert property (p_sd_clear) else $error("thermal shutdown not cleared");

  property p_fs_or;
    status_q[FSFB_BIT_FAILSAFE] == $past(failsafe_pin_flag | (|failsafe_fet_flags) | failsafe_pin_low);
  endproperty
  a_fs_or: assert property (p_fs_or) else $error("fail-safe summary wrong");

  property p_fs_clear_ignored;
    clr_hit && failsafe_pin_low |=> status_q[FSFB_BIT_FAILSAFE];
  endproperty
  a_fs_clear_ignored: assert property (p_fs_clear_ignored) else $error("fail-safe summary cleared");

  property p_fs_release;
    !failsafe_pin_low && !failsafe_pin_flag && failsafe_fet_flags == 4'h0 |=> !status_q[FSFB_BIT_FAILSAFE];
  endproperty
  a_fs_release: assert property (p_fs_release) else $error("fail-safe summary stuck");

  property p_pump_not_ready_bit_set;
    pump_start |=> status_q[FSFB_BIT_PUMP_PUMP_NOT_READY_BIT] [*2];
  endproperty
  a_pump_not_ready_bit_set: assert property (p_pump_not_ready_bit_set) else $error("not-ready not set on enable");

  property p_pump_not_ready_bit_clear;
    pump_enable && !pump_start && !pump_low_filt |=> !status_q[FSFB_BIT_PUMP_PUMP_NOT_READY_BIT];
  endproperty
  a_pump_not_ready_bit_clear: assert property (p_pump_not_ready_bit_clear) else $error("not-ready not cleared");

  property p_plow_live;
    pump_low_live_select |=> status_q[FSFB_BIT_PUMP_LOW] == $past(pump_low_filt);
  endproperty
  a_plow_live: assert property (p_plow_live) else $error("live pump-low mismatch");

  property p_plow_latched;
    !pump_low_live_select && pump_low_filt ##1 !pump_low_live_select && !clr_hit |=> status_q[FSFB_BIT_PUMP_LOW];
  endproperty
  a_plow_latched: assert property (p_plow_latched) else $error("pump-low not latched");

  property p_wdg_clear;
    clr_hit && !det_q[FSFB_BIT_WATCHDOG] |=> !status_q[FSFB_BIT_WATCHDOG];
  endproperty
  a_wdg_clear: assert property (p_wdg_clear) else $error("watchdog flag not cleared");

  property p_ds_set;
    det_q[FSFB_BIT_DS_HI:FSFB_BIT_DS_LO] != 4'h0 |=> status_q[FSFB_BIT_DS_HI:FSFB_BIT_DS_LO] != 4'h0;
  endproperty
  a_ds_set: assert property (p_ds_set) else $error("drain-source flag not set");

  property p_clear_active;
    clr_hit && det_q[FSFB_BIT_THERM_SD] |=> status_q[FSFB_BIT_THERM_SD];
  endproperty
  a_clear_active: assert property (p_clear_active) else $error("active fault cleared");

  c_clear_flag: cover property (status_q[FSFB_BIT_SUPPLY_OV] ##1 !status_q[FSFB_BIT_SUPPLY_OV]);
  c_pump_not_ready_bit_cycle: cover property (pump_start ##[1:1000] !status_q[FSFB_BIT_PUMP_PUMP_NOT_READY_BIT]);
  c_plow_live: cover property (pump_low_live_select && status_q[FSFB_BIT_PUMP_LOW]);
  c_fs_release: cover property (status_q[FSFB_BIT_FAILSAFE] ##1 !status_q[FSFB_BIT_FAILSAFE]);
endmodule // fsfb_status_bank

// ===== tb/fsfb_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the register link
// ----------------------------------------------------------------
module fsfb_host_model (
  // Clock
  input wire logic clk,
  // Strobes toward the bank
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_rd_clr
);
  // Idle at time zero, no strobe before reset ends
  initial begin
    reg_addr = 8'hA5;
    reg_rd = 1'b0;
    reg_rd_clr = 1'b0;
  end
  // Entered at a falling edge; the strobe spans exactly one rising edge
  task automatic access(input logic [7:0] a, input logic c);
    reg_addr = a;
    reg_rd = ~c;
    reg_rd_clr = c;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_rd_clr = 1'b0;
    // Released address changes, so a stale value cannot pass for a held one
    reg_addr = ~a;
  endtask
endmodule // fsfb_host_model

// ===== tb/fault_status_flag_bank_tb.sv
`timescale 1ns/1ps
module fault_status_flag_bank_tb;
  import fsfb_pkg::*;
  localparam int FILT = 4; // Short pump filter keeps the run brief
  localparam logic [7:0] OFF = FSFB_STATUS_ONE_OFFSET;
  logic clk, rst, reg_hit, pin, below, pen, lsel, pflag, tk, c7;
  logic reg_rd, reg_rd_clr;
  logic [7:0] reg_addr;
  logic [3:0] fets;
  logic [15:0] reg_rdata, status, ex, dv; // ex: expected word, dv: detector levels
  logic [15:0] q[$]; // Expected read data, oldest first
  int n_fail, total_checks, i, seed;
  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  fsfb_status_bank #(.PUMP_FILTER_CYCLES(FILT)) dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rd_clr(reg_rd_clr),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .supply_ov_det(dv[12]), .therm_warn_det(dv[11]),
    .therm_sd_det(dv[10]), .watchdog_det(dv[6]), .io_ov_det(dv[5]), .ds_monitor_det(dv[4:1]),
    .failsafe_input_pin(pin), .pump_below_det(below), .pump_enable(pen), .pump_low_live_select(lsel),
    .failsafe_fet_flags(fets), .failsafe_pin_flag(pflag), .device_fault_status_one(status));
  fsfb_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rd_clr(reg_rd_clr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Note taken strobes; address decode is combinational, so look at it now
  always @(posedge clk) begin
    tk <= reg_rd | reg_rd_clr;
    if ((reg_rd | reg_rd_clr) === 1'b1) begin
      chk("reg_hit", 16'(reg_addr == OFF), 16'(reg_hit));
    end
  end
  // Read data lands one edge after the strobe; compare away from the edge
  always @(negedge clk) begin
    if (tk === 1'b1) begin
      chk("reg_rdata", q.pop_front(), reg_rdata);
    end
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Note the pre-clear word, then drop every clearable bit whose source is gone
  task automatic acc(input logic [7:0] a, input logic c);
    q.push_back(a == OFF ? ex : 16'h0000);
    if (c && a == OFF) begin
      ex = ex & ~(FSFB_RC_MASK & ~dv) & ~{8'h00, c7, 7'h00};
    end
    host.access(a, c);
    @(negedge clk);
    // Live word must already show the outcome of the access
    chk("device_fault_status_one", ex, status);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    seed = 32'h1109ED1F;
    {rst, pin, lsel} = 3'b111;
    {below, pen, pflag, c7} = 4'b0000;
    fets = 4'h0;
    dv = 16'h0000;
    ex = FSFB_STATUS_RESET;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    wt(3);
    acc(OFF, 1'b0);
    acc(8'h02, 1'b0);
    // Random fault mixes; clears land with some sources still active
    for (i = 0; i < 12; i++) begin
      dv = 16'($random(seed)) & FSFB_RC_MASK;
      wt(5);
      ex = ex | dv;
      acc(OFF, 1'b1);
      if (i % 2 == 1) begin
        dv = 16'h0000;
        wt(5);
        acc(8'h00, 1'b1);
      end
      acc(OFF, 1'b1);
    end
    dv = 16'h0000;
    wt(5);
    acc(OFF, 1'b1);
    acc(OFF, 1'b0);
    // Fail-safe summary: floating pin, pin flag, each transistor flag
    for (i = 0; i < 6; i++) begin
      pin = (i != 0);
      pflag = (i == 1);
      fets = (i >= 2) ? 4'(1 << (i - 2)) : 4'h0;
      wt(5);
      ex[9] = 1'b1;
      acc(OFF, 1'b1);
      acc(OFF, 1'b0);
      {pin, pflag} = 2'b10;
      fets = 4'h0;
      wt(5);
      ex[9] = 1'b0;
      acc(OFF, 1'b0);
    end
    // Pump start with output low, live low bit
    {below, pen} = 2'b11;
    wt(FILT + 6);
    ex[8:7] = 2'b11;
    acc(OFF, 1'b1);
    below = 1'b0;
    wt(FILT);
    acc(OFF, 1'b0);
    wt(FILT);
    ex[8:7] = 2'b00;
    acc(OFF, 1'b0);
    // A dip shorter than the filter must not show
    below = 1'b1;
    wt(2);
    below = 1'b0;
    wt(FILT + 6);
    acc(OFF, 1'b0);
    // Latched low-pump mode
    lsel = 1'b0;
    below = 1'b1;
    wt(FILT + 6);
    ex[7] = 1'b1;
    acc(OFF, 1'b1);
    below = 1'b0;
    wt(FILT + 6);
    acc(OFF, 1'b0);
    c7 = 1'b1;
    acc(OFF, 1'b1);
    c7 = 1'b0;
    acc(OFF, 1'b0);
    wt(3);
    complete_run();
  end
endmodule // fault_status_flag_bank_tb
